//--- bench/test_uar_autobaud_rx.sv
// testbench: register-driven scenarios for the autobaud receiver
`default_nettype none
module test_uar_autobaud_rx import uar_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, lb = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic hready, hresp, rxd_in, txd_in, rxd_released, ser;
  wire logic [31:0] hrdata;
  int n_errors = 0, n_checks = 0;
  // loop-back routing: receive pin held low while released
  assign rxd_in = lb ? 1'b0 : ser;
  assign txd_in = lb ? ser : 1'b1;
  uar_autobaud_rx #(.DIV_RST(16'h0080)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .rxd_in(rxd_in), .txd_in(txd_in), .rxd_released(rxd_released));
  uar_tx_model u_tx (.hclk(hclk), .line(ser));
  initial forever #2 hclk = ~hclk;
  // one ahb single transfer, read data into q
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // break, sync character, idle gap
  task lrn(input int b, input int n, input logic [7:0] c);
    u_tx.brk(b);
    u_tx.send(c, n, 1'b1);
    u_tx.lvl(1'b1, 32);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial begin
    #40000;
    n_errors++;
    wrap_up;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(OFS_CTRL, 32'h0);
    rc(OFS_STATUS, 32'h0);
    rc(OFS_BAUD, 32'h80);
    rc(8'h10, 32'h0);
    u_tx.send(8'hA5, 16, 1'b1);
    rc(OFS_RXDATA, 32'h2A5);
    rc(OFS_RXDATA, 32'h0A5);
    u_tx.lvl(1'b0, 5);
    u_tx.lvl(1'b1, 40);
    rc(OFS_RXDATA, 32'h0A5);
    u_tx.send(8'h3C, 16, 1'b0);
    u_tx.lvl(1'b1, 40);
    rc(OFS_RXDATA, 32'h33C);
    xf(1'b1, OFS_CTRL, 32'h1);
    u_tx.send(8'h5A, 8, 1'b1);
    rc(OFS_RXDATA, 32'h25A);
    xf(1'b1, OFS_CTRL, 32'h2);
    lrn(40, 32, 8'h55);
    rc(OFS_BAUD, 32'h100);
    xf(1'b1, OFS_CTRL, 32'h0);
    u_tx.send(8'hC3, 32, 1'b1);
    rc(OFS_RXDATA, 32'h2C3);
    xf(1'b1, OFS_CTRL, 32'h2);
    lrn(60, 8, 8'h55);
    rc(OFS_BAUD, 32'h100);
    xf(1'b1, OFS_CTRL, 32'h3);
    u_tx.brk(40);
    u_tx.send(8'h54, 32, 1'b1);
    u_tx.send(8'hFF, 32, 1'b1);
    u_tx.lvl(1'b1, 32);
    rc(OFS_STATUS, 32'h1);
    rc(OFS_BAUD, 32'h100);
    xf(1'b1, OFS_CTRL, 32'h2);
    xf(1'b1, OFS_STATUS, 32'h3);
    rc(OFS_STATUS, 32'h2);
    lrn(6, 16, 8'h55);
    rc(OFS_BAUD, 32'h80);
    rc(OFS_STATUS, 32'h0);
    xf(1'b1, OFS_CTRL, 32'h4);
    rc(OFS_CTRL, 32'h4);
    chk({31'h0, rxd_released}, 32'h1);
    lb <= 1'b1;
    u_tx.send(8'h96, 16, 1'b1);
    rc(OFS_RXDATA, 32'h296);
    lb <= 1'b0;
    xf(1'b1, OFS_CTRL, 32'h0);
    rc(OFS_CTRL, 32'h0);
    chk({31'h0, rxd_released}, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire

//--- bench/uar_chk_sva.sv
// checker: bus, register and loop-back properties of the autobaud receiver
`default_nettype none
module uar_chk
  import uar_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic rxd_in,
  input wire logic txd_in,
  input wire logic rxd_released
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd;
  logic [7:0] a;
  logic wd_q;
  logic [2:0] sh_q;
  // read taken and decoded offset
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign a = haddr[7:0];
  // shadow of the last control word written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_q <= 1'b0;
      sh_q <= 3'h0;
    end else begin
      wd_q <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2 && a == OFS_CTRL;
      if (wd_q) sh_q <= hwdata[2:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(logic [7:0] o);
    rd && a == o;
  endsequence
  property p_ok; hresp == 1'b0; endproperty
  a_ok: assert property (p_ok) else $error("response not okay");
  property p_rdy; $past(hresetn) |-> hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("slave not ready");
  property p_ctrl; s_rd(OFS_CTRL) |=> hrdata == {29'h0, sh_q}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control word mismatch");
  property p_stat; s_rd(OFS_STATUS) |=> hrdata[31:3] == 29'h0; endproperty
  a_stat: assert property (p_stat) else $error("status upper bits set");
  property p_baud; s_rd(OFS_BAUD) |=> hrdata[31:16] == 16'h0; endproperty
  a_baud: assert property (p_baud) else $error("divisor upper bits set");
  property p_rxd; s_rd(OFS_RXDATA) |=> hrdata[31:10] == 22'h0; endproperty
  a_rxd: assert property (p_rxd) else $error("data upper bits set");
  property p_unm; rd && a[7:4] != 4'h0 |=> hrdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold; !rd |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_lb; wd_q |=> ##[0:1] rxd_released == sh_q[2]; endproperty
  a_lb: assert property (p_lb) else $error("receive pin release wrong");
endmodule
bind uar_autobaud_rx uar_chk u_chk (.*);
`default_nettype wire

//--- bench/uar_tx_model.sv
// remote serial transmitter model, idle high
`default_nettype none
module uar_tx_model (
  input wire logic hclk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // hold a level for n clocks, exact rate so zero own error
  task lvl(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge hclk);
  endtask
  // start, eight data bits lsb first, one stop of level sb
  task send(input logic [7:0] d, input int n, input logic sb);
    lvl(1'b0, n);
    for (int i = 0; i < 8; i++) lvl(d[i], n);
    lvl(sb, n);
  endtask
  // break low for n clocks, then a high gap before sync
  task brk(input int n);
    lvl(1'b0, n);
    lvl(1'b1, 16);
  endtask
endmodule
`default_nettype wire

//--- rtl/uar_autobaud_rx.sv
// module: oversampling serial receiver with rate learning, single-wire loop-back and an AHB-Lite register slave
`default_nettype none

module uar_autobaud_rx
  import uar_pkg::*;
#(
  parameter logic [15:0] DIV_RST = DIV_RST_DEFAULT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rxd_in,
  input wire logic txd_in,
  output logic rxd_released
);

  // ----------------------------------------
  // elaboration check and reset state
  // ----------------------------------------
  if (DIV_RST < TICK_STEP[15:0]) begin
    $error("DIV_RST below one sample tick per clock");
  end

  // idle line levels high so reset gives no false edge
  localparam uar_state_s STATE_RST = '{
    rxd_meta: 1'b1,
    rxd_sync: 1'b1,
    txd_meta: 1'b1,
    txd_sync: 1'b1,
    line_prev: 1'b1,
    mode: MODE_NORMAL,
    baud: DIV_RST,
    st: ST_IDLE,
    default: '0
  };

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // samples per bit for a mode
  function automatic logic [4:0] samp_per_bit(input uar_mode_e m);
    return (m == MODE_DOUBLE) ? SAMP_DOUBLE : SAMP_NORMAL;
  endfunction

  // first vote sample for a mode
  function automatic logic [4:0] vote_first(input uar_mode_e m);
    return (m == MODE_DOUBLE) ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  endfunction

  // centre vote sample for a mode
  function automatic logic [4:0] vote_mid(input uar_mode_e m);
    return (m == MODE_DOUBLE) ? VOTE_MID_DOUBLE : VOTE_MID_NORMAL;
  endfunction

  uar_state_s s;
  uar_state_s n;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic line;
    logic rise;
    logic fall;
    logic tick;
    logic bitv;
    logic inwin;
    logic learn;
    logic brk_hit;
    logic ok55;
    logic [1:0] vn;
    logic [4:0] sn;
    logic [4:0] spb;
    logic [4:0] sf;
    logic [4:0] slast;
    logic [16:0] sum;
    logic [18:0] q4;
    logic [18:0] m19;
    logic [18:0] dev;
    line = 1'b1;
    rise = 1'b0;
    fall = 1'b0;
    tick = 1'b0;
    bitv = 1'b0;
    inwin = 1'b0;
    learn = 1'b0;
    brk_hit = 1'b0;
    ok55 = 1'b0;
    vn = 2'b00;
    sn = 5'h00;
    spb = 5'h00;
    sf = 5'h00;
    slast = 5'h00;
    sum = 17'h00000;
    q4 = 19'h00000;
    m19 = 19'h00000;
    dev = 19'h00000;
    n = s;

    // pin synchronisers, then source select
    n.rxd_meta = rxd_in;
    n.rxd_sync = s.rxd_meta;
    n.txd_meta = txd_in;
    n.txd_sync = s.txd_meta;
    line = s.loopback_single_wire_enable ? s.txd_sync : s.rxd_sync;
    n.line_prev = line;
    rise = line & ~s.line_prev;
    fall = ~line & s.line_prev;
    n.rxd_free = s.loopback_single_wire_enable;

    // bus slave: zero wait, always okay
    n.hready_q = 1'b1;
    n.hresp_q = 1'b0;
    n.ap_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.ap_addr = haddr[7:0];
      n.ap_wr = hwrite && (hsize == 3'b010);
      if (!hwrite) begin
        case (haddr[7:0])
          OFS_CTRL: n.hrdata = {29'h0, s.loopback_single_wire_enable, s.mode};
          OFS_STATUS: n.hrdata = {29'h0, s.st != ST_IDLE, s.break_any_length_wait, s.syncerr};
          OFS_BAUD: n.hrdata = {16'h0, s.baud};
          OFS_RXDATA: begin
            n.hrdata = {22'h0, s.valid, s.ferr, s.rxdata};
            n.valid = 1'b0; // reading takes the frame
          end
          default: n.hrdata = 32'h0;
        endcase
      end
    end

    // write data phase
    if (s.ap_wr) begin
      case (s.ap_addr)
        OFS_CTRL: begin
          n.mode = uar_mode_e'(hwdata[CTRL_MODE_LSB +: 2]);
          n.loopback_single_wire_enable = hwdata[CTRL_LOOPBACK_SINGLE_WIRE_ENABLE_BIT];
        end
        OFS_STATUS: begin
          if (hwdata[STAT_SYNCERR_BIT]) begin
            n.syncerr = 1'b0;
          end
          n.break_any_length_wait = hwdata[STAT_WFB_BIT];
        end
        OFS_BAUD: n.baud = hwdata[15:0];
        // unmapped write ignored; a newly taken address phase must survive
        default: n.hresp_q = 1'b0;
      endcase
    end

    // sample tick: one tick per baud/128 clocks, in both speeds
    spb = samp_per_bit(s.mode);
    sf = vote_first(s.mode);
    slast = vote_mid(s.mode) + 5'h01;
    sum = s.acc + TICK_STEP;
    tick = sum >= {1'b0, s.baud};
    n.acc = tick ? sum - {1'b0, s.baud} : sum;
    if (tick && (s.baud < TICK_STEP[15:0])) begin
      n.acc = 17'h00000;
    end

    // sample counter and vote accumulation
    sn = (s.scnt == spb) ? 5'h01 : s.scnt + 5'h01;
    inwin = (sn >= sf) && (sn <= slast);
    vn = s.votes + {1'b0, line};
    bitv = vn[1];

    // frame receiver
    case (s.st)
      ST_IDLE: begin
        if (tick && !line) begin
          n.st = ST_START;
          n.scnt = 5'h01;
          n.votes = 2'b00;
          n.bitn = 3'h0;
        end
      end
      ST_START, ST_DATA, ST_STOP: begin
        if (tick) begin
          n.scnt = sn;
          if (inwin) begin
            n.votes = vn;
          end
          if (sn == slast) begin
            n.votes = 2'b00;
            if (s.st == ST_START && bitv) begin
              n.st = ST_IDLE;
            end
            if (s.st == ST_DATA) begin
              n.shreg = {bitv, s.shreg[7:1]};
            end
            if (s.st == ST_STOP) begin
              n.rxdata = s.shreg;
              n.ferr = ~bitv;
              n.valid = 1'b1;
              n.st = ST_IDLE;
            end
          end
          if (sn == spb && s.st == ST_START) begin
            n.st = ST_DATA;
          end
          if (sn == spb && s.st == ST_DATA) begin
            if (s.bitn == 3'h7) begin
              n.st = ST_STOP;
            end else begin
              n.bitn = s.bitn + 3'h1;
            end
          end
        end
      end
      ST_SYNCW: begin
        if (fall) begin
          n.st = ST_MEAS;
          n.mcnt = 17'h00001; // the start edge's own cycle is the first one counted
          n.nfall = 3'h0;
        end
      end
      ST_MEAS: begin
        if (s.mcnt != MEAS_SAT) begin
          n.mcnt = s.mcnt + 17'h00001;
        end else begin
          n.st = ST_IDLE;
          if (s.mode == MODE_LIN) begin
            n.syncerr = 1'b1;
          end
        end
        if (fall) begin
          n.nfall = s.nfall + 3'h1;
          if (s.nfall == 3'h0) begin
            n.iv1 = s.mcnt;
          end
          if (s.nfall == SYNC_FALLS - 3'h1) begin
            // eighth bit edge reached: candidate is complete
            n.st = ST_TAIL;
            q4 = {s.iv1, 2'b00};
            m19 = {2'b00, s.mcnt};
            dev = (q4 > m19) ? q4 - m19 : m19 - q4;
            ok55 = dev <= (m19 >> 3);
            if (s.mode == MODE_LIN && !ok55) begin
              n.syncerr = 1'b1;
            end else if (s.mcnt >= DIV_MIN && s.mcnt <= DIV_MAX) begin
              n.baud = s.mcnt[15:0];
            end
          end
        end
      end
      ST_TAIL: begin
        if (line) begin
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // break detector for the learning modes
    learn = s.mode[1];
    if (!learn) begin
      n.brk = 4'h0;
      if (s.st == ST_SYNCW || s.st == ST_MEAS || s.st == ST_TAIL) begin
        n.st = ST_IDLE;
      end
    end else begin
      if (line) begin
        n.brk = 4'h0;
      end else if ((s.mode == MODE_LIN || tick) && s.brk != 4'hF) begin
        n.brk = s.brk + 4'h1;
      end
      brk_hit = rise && ((s.brk >= BRK_MIN) || (s.mode == MODE_GENERIC && s.break_any_length_wait));
      if (brk_hit && s.st != ST_MEAS && s.st != ST_TAIL) begin
        n.st = ST_SYNCW;
        n.break_any_length_wait = 1'b0;
        n.votes = 2'b00;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign hreadyout = s.hready_q;
  assign hresp = s.hresp_q;
  assign hrdata = s.hrdata;
  assign rxd_released = s.rxd_free;

endmodule
`default_nettype wire

//--- rtl/uar_pkg.sv
// package: register map, field layout, timing counts and types of the autobaud receiver
`default_nettype none
package uar_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LOOPBACK_SINGLE_WIRE_ENABLE_BIT = 2;
  localparam int STAT_SYNCERR_BIT = 0;
  localparam int STAT_WFB_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int RXD_FERR_BIT = 8;
  localparam int RXD_VALID_BIT = 9;

  // ----------------------------------------
  // sampling and learning counts
  // ----------------------------------------
  localparam logic [4:0] SAMP_NORMAL = 5'h10;
  localparam logic [4:0] SAMP_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_MID_NORMAL = 5'h09;
  localparam logic [4:0] VOTE_MID_DOUBLE = 5'h05;
  localparam logic [3:0] BRK_MIN = 4'hC;
  localparam logic [16:0] DIV_MIN = 17'h00064;
  localparam logic [16:0] DIV_MAX = 17'h0FFFF;
  localparam logic [16:0] MEAS_SAT = 17'h1FFFF;
  localparam logic [16:0] TICK_STEP = 17'h00080;
  localparam logic [2:0] SYNC_FALLS = 3'h4;
  localparam logic [15:0] DIV_RST_DEFAULT = 16'h0D80;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_DOUBLE = 2'b01,
    MODE_GENERIC = 2'b10,
    MODE_LIN = 2'b11
  } uar_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_STOP = 3'b011,
    ST_SYNCW = 3'b100,
    ST_MEAS = 3'b101,
    ST_TAIL = 3'b110
  } uar_state_e;

  typedef struct packed {
    logic rxd_meta;
    logic rxd_sync;
    logic txd_meta;
    logic txd_sync;
    logic line_prev;
    uar_mode_e mode;
    logic loopback_single_wire_enable;
    logic break_any_length_wait;
    logic syncerr;
    logic [15:0] baud;
    logic [16:0] acc;
    uar_state_e st;
    logic [4:0] scnt;
    logic [1:0] votes;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic [7:0] rxdata;
    logic ferr;
    logic valid;
    logic [3:0] brk;
    logic [16:0] mcnt;
    logic [16:0] iv1;
    logic [2:0] nfall;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hready_q;
    logic hresp_q;
    logic rxd_free;
  } uar_state_s;

endpackage
`default_nettype wire
